//--- rtl/smwss_top.sv
// Stop-mode wake source selector with AXI4-Lite register access.
//
// Behaviour
// - Second register keeps source bits 2-4 and level bit 6, write-only.
// - Code 000 POR only; 001 NAND port2 bits 0-3; 010 NAND port2 bits 0-7.
// - Code 011 NOR port3 bits 1-3; code 100 NAND of those three.
// - 101 NOR/110 NAND port3 1-3 with port0 0,7; 111 NAND port3 1-3 with port2 0-2.
// - Level bit chooses low or high active level of the selected combination.
// - Either register's selected event ends stop mode, whichever comes first.
// - Pins configured as outputs are dropped from the wake equation.
// - Primary register bits 6-0 write-only, bit 7 read-only.
// - Hardware sets primary bit 7 when stop mode ends by a recovery event.
// - Delay field takes its default on power-on only, kept through recovery.
// - Port 3 mode register write-only, reset by power-on, kept through recovery.
// - The recovery flag is cleared only by power-on reset.
// - Primary bit 5 decides whether the power-on timer runs after the wake event, before recovery.
`timescale 1ns/10ps
`default_nettype none
`include "smwss_map.svh"

module smwss_top
  import smwss_pkg::*;
#(
  parameter int POR_DELAY_CYCLES = `SMWSS_POR_DELAY_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] port0_pin,
  input wire logic [7:0] port2_pin,
  input wire logic [7:0] port3_pin,
  input wire logic [7:0] port0_is_output,
  input wire logic [7:0] port2_is_output,
  input wire logic [7:0] port3_is_output,
  output logic stop_active,
  output logic por_timer_active,
  output logic recovery_reset,
  output logic sclk_div16,
  output logic crystal_select,
  output logic [7:0] port3_mode,
  output logic irq
);

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic [11:0] smwss_byte_addr(input logic [9:0] idx);
    smwss_byte_addr = {idx, 2'b00};
  endfunction : smwss_byte_addr

  function automatic logic smwss_mapped(input logic [11:0] addr);
    smwss_mapped = (addr == smwss_byte_addr(`SMWSS_IDX_SEL)) || (addr == smwss_byte_addr(`SMWSS_IDX_SEL2)) ||
                   (addr == smwss_byte_addr(`SMWSS_IDX_PORT3_MODE)) || (addr == `SMWSS_ADDR_CTRL) ||
                   (addr == `SMWSS_ADDR_STATUS) || (addr == `SMWSS_ADDR_MASK);
  endfunction : smwss_mapped

  // Returns one when the selected combination reaches the selected level.
  function automatic logic smwss_wake(input logic [2:0] code, input logic level, input smwss_pins_t pins,
                                      input smwss_pins_t outs);
    logic [7:0] p0_and;
    logic [7:0] p2_and;
    logic [7:0] p3_and;
    logic [7:0] p0_or;
    logic [7:0] p2_or;
    logic [7:0] p3_or;
    logic comb;
    logic valid;
    p0_and = pins.p0 | outs.p0;
    p2_and = pins.p2 | outs.p2;
    p3_and = pins.p3 | outs.p3;
    p0_or = pins.p0 & ~outs.p0;
    p2_or = pins.p2 & ~outs.p2;
    p3_or = pins.p3 & ~outs.p3;
    valid = 1'b1;
    comb = 1'b0;
    unique case (code)
      3'h0: begin
        valid = 1'b0;
      end
      3'h1: begin
        comb = ~&p2_and[3:0];
      end
      3'h2: begin
        comb = ~&p2_and;
      end
      3'h3: begin
        comb = ~|p3_or[3:1];
      end
      3'h4: begin
        comb = ~&p3_and[3:1];
      end
      3'h5: begin
        comb = ~(|p3_or[3:1] | p0_or[0] | p0_or[7]);
      end
      3'h6: begin
        comb = ~(&p3_and[3:1] & p0_and[0] & p0_and[7]);
      end
      3'h7: begin
        comb = ~(&p3_and[3:1] & &p2_and[2:0]);
      end
    endcase
    smwss_wake = valid & ~(comb ^ level);
  endfunction : smwss_wake

  // ----------------------------------------
  // State
  // ----------------------------------------
  smwss_state_t st;
  smwss_state_t next_st;
  logic do_write;
  logic [7:0] wr_data;
  logic wake;
  smwss_pins_t outs;
  smwss_pins_t agree;

  always_comb begin
    next_st = st;
    outs = '{p0: port0_is_output, p2: port2_is_output, p3: port3_is_output};
    do_write = 1'b0;
    wr_data = st.w_data;
    // Pins pass three flops; a change counts once stages two and three agree.
    next_st.s1 = '{p0: port0_pin, p2: port2_pin, p3: port3_pin};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    agree = ~(st.s2 ^ st.s3);
    next_st.clean = (st.s3 & agree) | (st.clean & ~agree);
    wake = smwss_wake(st.stop_recovery_select[`SMWSS_SRC_HI:`SMWSS_SRC_LO],
                      st.stop_recovery_select[`SMWSS_SEL_LEVEL], st.clean, outs) |
           smwss_wake(st.stop_recovery_select_second[`SMWSS_SRC_HI:`SMWSS_SRC_LO],
                      st.stop_recovery_select_second[`SMWSS_SEL_LEVEL], st.clean, outs);

    // AXI4-Lite write: address and data are taken in either order.
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_full = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_full = 1'b1;
      next_st.w_data = s_axi_wdata[7:0];
      next_st.w_lane0 = s_axi_wstrb[0];
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_full && st.w_full && !st.bvalid) begin
      do_write = st.w_lane0;
      next_st.aw_full = 1'b0;
      next_st.w_full = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = smwss_mapped(st.aw_addr) ? 2'h0 : 2'h2;
    end
    next_st.awready = !next_st.aw_full;
    next_st.wready = !next_st.w_full;

    // AXI4-Lite read: write-only storage reads as zero.
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = smwss_mapped(s_axi_araddr) ? 2'h0 : 2'h2;
      next_st.rdata = 8'h00;
      if (s_axi_araddr == smwss_byte_addr(`SMWSS_IDX_SEL)) begin
        next_st.rdata[`SMWSS_SEL_FLAG] = st.stop_recovery_select[`SMWSS_SEL_FLAG];
      end else if (s_axi_araddr == `SMWSS_ADDR_CTRL) begin
        next_st.rdata[`SMWSS_CTRL_STOP] = (st.mode != SMWSS_RUN);
      end else if (s_axi_araddr == `SMWSS_ADDR_STATUS) begin
        next_st.rdata[1:0] = st.int_status;
      end else if (s_axi_araddr == `SMWSS_ADDR_MASK) begin
        next_st.rdata[1:0] = st.int_mask;
      end
    end
    next_st.arready = !next_st.rvalid;

    // Register writes.
    if (do_write) begin
      if (st.aw_addr == smwss_byte_addr(`SMWSS_IDX_SEL)) begin
        next_st.stop_recovery_select = {st.stop_recovery_select[`SMWSS_SEL_FLAG], wr_data[6:0]};
      end else if (st.aw_addr == smwss_byte_addr(`SMWSS_IDX_SEL2)) begin
        next_st.stop_recovery_select_second = wr_data & `SMWSS_SEL2_WMASK;
      end else if (st.aw_addr == smwss_byte_addr(`SMWSS_IDX_PORT3_MODE)) begin
        next_st.port3_mode_control = wr_data;
      end else if (st.aw_addr == `SMWSS_ADDR_STATUS) begin
        next_st.int_status = st.int_status & ~wr_data[1:0];
      end else if (st.aw_addr == `SMWSS_ADDR_MASK) begin
        next_st.int_mask = wr_data[1:0];
      end
    end

    // Stop and recovery sequence.
    next_st.recovery_reset = 1'b0;
    unique case (st.mode)
      SMWSS_RUN: begin
        if (do_write && st.aw_addr == `SMWSS_ADDR_CTRL && wr_data[`SMWSS_CTRL_STOP]) begin
          next_st.mode = SMWSS_STOP;
          next_st.int_status[`SMWSS_INT_STOPPED] = 1'b1;
        end
      end
      SMWSS_STOP: begin
        if (wake) begin
          if (st.stop_recovery_select[`SMWSS_SEL_DELAY]) begin
            next_st.mode = SMWSS_DELAY;
            next_st.delay_cnt = 16'(POR_DELAY_CYCLES - 1);
          end else begin
            next_st.mode = SMWSS_RECOVER;
          end
        end
      end
      SMWSS_DELAY: begin
        if (st.delay_cnt == 16'h0000) begin
          next_st.mode = SMWSS_RECOVER;
        end else begin
          next_st.delay_cnt = st.delay_cnt - 16'h0001;
        end
      end
      SMWSS_RECOVER: begin
        next_st.mode = SMWSS_RUN;
        next_st.recovery_reset = 1'b1;
        next_st.stop_recovery_select = (`SMWSS_SEL_RESET & ~`SMWSS_SEL_KEEP) |
                                       (st.stop_recovery_select & `SMWSS_SEL_KEEP);
        next_st.stop_recovery_select[`SMWSS_SEL_FLAG] = 1'b1;
        next_st.stop_recovery_select_second = `SMWSS_SEL2_RESET;
        next_st.port3_mode_control = st.port3_mode_control;
        next_st.int_status[`SMWSS_INT_RECOVERED] = 1'b1;
      end
    endcase
    next_st.stop_active = (next_st.mode == SMWSS_STOP);
    next_st.por_timer_active = (next_st.mode == SMWSS_DELAY);
    next_st.irq = |(next_st.int_status & next_st.int_mask);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
      st.stop_recovery_select <= `SMWSS_SEL_RESET;
      st.stop_recovery_select_second <= `SMWSS_SEL2_RESET;
      st.port3_mode_control <= `SMWSS_PORT3_MODE_RESET;
      st.mode <= SMWSS_RUN;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = {24'h000000, st.rdata};
  assign stop_active = st.stop_active;
  assign por_timer_active = st.por_timer_active;
  assign recovery_reset = st.recovery_reset;
  assign sclk_div16 = st.stop_recovery_select[`SMWSS_SEL_DIV16];
  assign crystal_select = st.stop_recovery_select[`SMWSS_SEL_CRYSTAL];
  assign port3_mode = st.port3_mode_control;
  assign irq = st.irq;

endmodule : smwss_top

`default_nettype wire

//--- rtl/smwss_map.svh
// Register map, field positions, reset values and timing counts of the wake source selector.
`ifndef SMWSS_MAP_SVH
`define SMWSS_MAP_SVH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define SMWSS_IDX_SEL 10'h00B
`define SMWSS_IDX_SEL2 10'h00D
`define SMWSS_IDX_PORT3_MODE 10'h0F7
`define SMWSS_ADDR_CTRL 12'h400
`define SMWSS_ADDR_STATUS 12'h404
`define SMWSS_ADDR_MASK 12'h408

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SMWSS_SEL_FLAG 7
`define SMWSS_SEL_LEVEL 6
`define SMWSS_SEL_DELAY 5
`define SMWSS_SRC_LO 2
`define SMWSS_SRC_HI 4
`define SMWSS_SEL_CRYSTAL 1
`define SMWSS_SEL_DIV16 0
`define SMWSS_SEL2_WMASK 8'h5C
`define SMWSS_SEL_KEEP 8'hA0
`define SMWSS_CTRL_STOP 0
`define SMWSS_INT_RECOVERED 0
`define SMWSS_INT_STOPPED 1

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define SMWSS_SEL_RESET 8'h20
`define SMWSS_SEL2_RESET 8'h00
`define SMWSS_PORT3_MODE_RESET 8'h00
`define SMWSS_CLK_PERIOD_NS 40
`define SMWSS_POR_DELAY_NS 2500000
`define SMWSS_POR_DELAY_CYCLES ((`SMWSS_POR_DELAY_NS + `SMWSS_CLK_PERIOD_NS - 1) / `SMWSS_CLK_PERIOD_NS)

`endif

//--- rtl/smwss_pkg.sv
// Types shared by the wake source selector.
package smwss_pkg;

  typedef enum logic [1:0] {SMWSS_RUN, SMWSS_STOP, SMWSS_DELAY, SMWSS_RECOVER} smwss_mode_t;

  typedef struct packed {
    logic [7:0] p0;
    logic [7:0] p2;
    logic [7:0] p3;
  } smwss_pins_t;

  typedef struct packed {
    smwss_pins_t s1;
    smwss_pins_t s2;
    smwss_pins_t s3;
    smwss_pins_t clean;
    logic awready;
    logic wready;
    logic arready;
    logic aw_full;
    logic [11:0] aw_addr;
    logic w_full;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] stop_recovery_select;
    logic [7:0] stop_recovery_select_second;
    logic [7:0] port3_mode_control;
    logic [1:0] int_status;
    logic [1:0] int_mask;
    smwss_mode_t mode;
    logic [15:0] delay_cnt;
    logic recovery_reset;
    logic stop_active;
    logic por_timer_active;
    logic irq;
  } smwss_state_t;

endpackage : smwss_pkg

//--- dv/smwss_pin_model.sv
// External logic driving the port input pins.
`timescale 1ns/10ps
`default_nettype none

module smwss_pin_model (
  input wire logic aclk,
  input wire logic [23:0] want,
  output logic [23:0] pins
);
  // Pins follow the requested levels one cycle later.
  always @(posedge aclk) begin
    pins <= want;
  end
endmodule : smwss_pin_model

`default_nettype wire

//--- dv/smwss_monitor.sv
// Bus and wake sequence checker for the wake source selector.
`timescale 1ns/10ps
`default_nettype none

module smwss_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic stop_active,
  input wire logic por_timer_active,
  input wire logic recovery_reset
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // --------
  // Bus
  // --------
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000 &&
                                    (s_axi_rresp == 2'h0 || s_axi_rdata[7:0] == 8'h00))
    else $error("read data not zero where required");
  chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready during read answer");
  // --------
  // Wake
  // --------
  chk_rec_pulse: assert property (recovery_reset |=> !recovery_reset)
    else $error("recovery pulse too long");
  chk_rec_awake: assert property (recovery_reset |-> !stop_active && !por_timer_active)
    else $error("recovery while stopped");
  chk_wake_bound: assert property ($fell(stop_active) |-> ##[1:16] recovery_reset)
    else $error("no recovery after wake");
  chk_timer_len: assert property ($rose(por_timer_active) |-> por_timer_active [*8] ##1 !por_timer_active)
    else $error("delay timer length wrong");
endmodule : smwss_monitor

bind smwss_top smwss_monitor mon_u (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stop_active, .por_timer_active, .recovery_reset);

`default_nettype wire

//--- dv/tb_stop_mode_wake_source_select.sv
// Testbench for the stop-mode wake source selector.
`timescale 1ns/10ps
`default_nettype none

module tb_stop_mode_wake_source_select;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [23:0] want = 24'h0, dir = 24'h0, pins;
  logic awready, wready, bvalid, arready, rvalid, stop_active, por_timer_active, recovery_reset, irq, sdiv, xtal;
  logic [1:0] bresp, rresp;
  logic [7:0] port3_mode;
  int num_errors = 0, checks = 0;
  // Rows: primary, second, port 3 direction, idle pins, wake pins.
  localparam logic [71:0] ROWS [10] = '{72'h20_04_00_000700_000F00, 72'h00_08_00_007F00_00FF00,
    72'h00_0C_00_0000F1_000008, 72'h00_10_00_000006_00000E, 72'h00_14_00_7E00F1_800000,
    72'h00_18_00_01000E_81000E, 72'h00_1C_00_00030E_00070E, 72'h00_50_00_00000E_00000C,
    72'h00_10_08_000002_000006, 72'h10_04_00_000006_00000E};
  always #20 aclk = ~aclk;
  smwss_pin_model pin_u (.aclk(aclk), .want(want), .pins(pins));
  smwss_top #(.POR_DELAY_CYCLES(8)) dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port0_pin(pins[23:16]), .port2_pin(pins[15:8]), .port3_pin(pins[7:0]), .port0_is_output(dir[23:16]),
    .port2_is_output(dir[15:8]), .port3_is_output(dir[7:0]), .stop_active(stop_active),
    .por_timer_active(por_timer_active), .recovery_reset(recovery_reset), .sclk_div16(sdiv),
    .crystal_select(xtal), .port3_mode(port3_mode), .irq(irq));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic limit(input int n);
    if (n > 60) begin
      num_errors++;
      complete_run();
    end
  endtask : limit
  task automatic cycles(input int n);
    repeat (n) @(posedge aclk);
  endtask : cycles
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] exp);
    logic aw, w, b;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 99; i++) begin
      limit(i);
      #1;
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid & bready;
      r = bresp;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) begin
        bready <= 1'b0;
        chk(32'(r), 32'(exp));
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp_d, input logic [1:0] exp_r);
    logic ar, r;
    logic [31:0] d;
    logic [1:0] rr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 99; i++) begin
      limit(i);
      #1;
      ar = arvalid & arready;
      r = rvalid & rready;
      d = rdata;
      rr = rresp;
      @(posedge aclk);
      if (ar) arvalid <= 1'b0;
      if (r) begin
        rready <= 1'b0;
        chk(d, exp_d);
        chk(32'(rr), 32'(exp_r));
        break;
      end
    end
  endtask : rd
  task automatic t_regs;
    rd(12'h02C, 32'h0, 2'h0);
    rd(12'h034, 32'h0, 2'h0);
    wr(12'h3DC, 8'hA5, 2'h0);
    rd(12'h3DC, 32'h0, 2'h0);
    chk(32'(port3_mode), 32'hA5);
    wr(12'h02C, 8'h03, 2'h0);
    chk(32'({xtal, sdiv}), 32'h3);
    rd(12'h100, 32'h0, 2'h2);
    $display("test regs done");
  endtask : t_regs
  task automatic t_wake(input logic [71:0] row);
    int seen;
    int tmr;
    seen = 0;
    tmr = 0;
    wr(12'h02C, row[71:64], 2'h0);
    wr(12'h034, row[63:56], 2'h0);
    dir <= {16'h0000, row[55:48]};
    want <= row[47:24];
    cycles(8);
    wr(12'h400, 8'h01, 2'h0);
    cycles(12);
    chk(32'(stop_active), 32'h1);
    want <= row[23:0];
    for (int i = 0; i < 40 && seen == 0; i++) begin
      @(posedge aclk);
      #1;
      tmr += int'(por_timer_active !== 1'b0);
      seen += recovery_reset;
    end
    chk(seen, 1);
    chk(tmr, row[69] ? 8 : 0);
    rd(12'h02C, 32'h80, 2'h0);
    $display("test wake %h done", row[63:56]);
  endtask : t_wake
  task automatic t_irq;
    chk(32'(irq), 32'h0);
    rd(12'h404, 32'h3, 2'h0);
    wr(12'h408, 8'h01, 2'h0);
    cycles(2);
    chk(32'(irq), 32'h1);
    wr(12'h404, 8'h03, 2'h0);
    cycles(2);
    chk(32'(irq), 32'h0);
    rd(12'h404, 32'h0, 2'h0);
    chk(32'(port3_mode), 32'hA5);
    $display("test irq done");
  endtask : t_irq
  task automatic t_nowake;
    wr(12'h02C, 8'h00, 2'h0);
    wr(12'h034, 8'h00, 2'h0);
    wr(12'h400, 8'h01, 2'h0);
    want <= 24'hFFFFFF;
    cycles(10);
    want <= 24'h000000;
    cycles(10);
    chk(32'(stop_active), 32'h1);
    aresetn <= 1'b0;
    cycles(2);
    aresetn <= 1'b1;
    cycles(1);
    chk(32'(stop_active), 32'h0);
    rd(12'h02C, 32'h0, 2'h0);
    $display("test no wake done");
  endtask : t_nowake
  initial begin
    cycles(12);
    aresetn <= 1'b1;
    t_regs();
    for (int k = 0; k < 10; k++) t_wake(ROWS[k]);
    t_irq();
    t_nowake();
    complete_run();
  end
endmodule : tb_stop_mode_wake_source_select

`default_nettype wire
